// *** msl_pkg.sv ***
// Constants and types shared by the multidrop serial link design.
// Operation
// (RL1) Station answers only frames whose address equals its 0..31 setting.
// (RL2) Host addresses at most 32 stations on the shared bus.
// (RL3) Bit rate is 19200, 9600 or 4800, picked by the rate setting.
// (RL4) Characters carry seven or eight data bits.
// (RL5) Characters end with one or two stop bits.
// (RL6) Parity is none, odd or even; received parity is checked.
// (RL7) An optional waiting interval precedes the station reply.
// (RL8) Received 65520 becomes 8888 and 65535 becomes 9999.
// (RL9) New settings act only after a device reset.
// (RL10) No exchange when settings are invalid.
// (RL11) Stop/length codes: 0, 1, 10, 11 select 8/1, 8/2, 7/1, 7/2.
// (RL12) Consecutive errors above the 0..10 retry limit trip the link.
// (RL13) Retry limit 9999 never trips; minor fault shows while errors last.
// (RL14) One driver at a time; station releases the line after replying.
// (RL15) Frames carry a sum check; a mismatch counts as a receive error.
package msl_pkg;
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned BPS_19200     = 19200;
  localparam int unsigned BPS_9600      = 9600;
  localparam int unsigned BPS_4800      = 4800;
  localparam int unsigned CYC_19200     = CLK_HZ / BPS_19200;
  localparam int unsigned CYC_9600      = CLK_HZ / BPS_9600;
  localparam int unsigned CYC_4800      = CLK_HZ / BPS_4800;
  localparam int          CW            = 13;
  localparam int          GAP_SHIFT     = 4;
  localparam int          GW            = CW + GAP_SHIFT;
  localparam logic [3:0]  WAIT_LAST     = 4'h9;

  localparam logic [15:0] ADDR_MAX      = 16'h001F;
  localparam logic [15:0] RATE_4800     = 16'h0030;
  localparam logic [15:0] RATE_9600     = 16'h0060;
  localparam logic [15:0] RATE_19200    = 16'h00C0;
  localparam logic [15:0] SL_8_1        = 16'h0000;
  localparam logic [15:0] SL_8_2        = 16'h0001;
  localparam logic [15:0] SL_7_1        = 16'h000A;
  localparam logic [15:0] SL_7_2        = 16'h000B;
  localparam logic [15:0] PAR_NONE      = 16'h0000;
  localparam logic [15:0] PAR_ODD       = 16'h0001;
  localparam logic [15:0] PAR_EVEN      = 16'h0002;
  localparam logic [15:0] RETRY_MAX     = 16'h000A;
  localparam logic [15:0] RETRY_INF     = 16'h270F;
  localparam logic [15:0] RETRY_INF_RAW = 16'hFFFF;
  localparam logic [15:0] RAW_8888      = 16'hFFF0;
  localparam logic [15:0] RAW_9999      = 16'hFFFF;
  localparam logic [15:0] VAL_8888      = 16'h22B8;
  localparam logic [15:0] VAL_9999      = 16'h270F;
  localparam logic [15:0] ADDR_RESET    = 16'h0000;
  localparam logic [15:0] RATE_RESET    = 16'h00C0;

  localparam logic [7:0]  CHAR_ACK      = 8'h06;
  localparam logic [7:0]  CHAR_NAK      = 8'h15;
  localparam logic [7:0]  CHAR_CR       = 8'h0D;
  localparam logic [7:0]  CHAR_LF       = 8'h0A;
  localparam logic [2:0]  LAST_BIT7     = 3'h6;
  localparam logic [2:0]  LAST_BIT8     = 3'h7;
  localparam logic [1:0]  IDX_LAST      = 2'h3;
  localparam logic [4:0]  ERR_SAT       = 5'h1F;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
    msl_rx_e;
  typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_START, TX_DATA, TX_PAR,
    TX_STOP} msl_tx_e;

  function automatic logic [15:0] msl_xlate(input logic [15:0] raw);
    if (raw == RAW_8888)
      msl_xlate = VAL_8888;
    else if (raw == RAW_9999)
      msl_xlate = VAL_9999;
    else
      msl_xlate = raw;
  endfunction : msl_xlate
endpackage : msl_pkg

// *** msl_buf_if.sv ***
// Valid/ready word channel between the link logic and its buffer.
`timescale 1ns/1ps
`default_nettype none
interface msl_buf_if #(parameter int W = 16);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : msl_buf_if
`default_nettype wire

// *** msl_fifo2.sv ***
// Small valid/ready buffer for received parameter words.
`timescale 1ns/1ps
`default_nettype none
module msl_fifo2 #(
  parameter int W     = 16,
  parameter int DEPTH = 2
) (
  input wire logic mclk,
  input wire logic reset_n,
  msl_buf_if.snk   wr,
  msl_buf_if.src   rd
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0]   cnt_ff;
  logic          push;
  logic          pop;

  assign wr.ready = (cnt_ff != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_ff != '0);
  assign rd.data  = mem_ff[rp_ff];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_ff[i] <= '0;
      wp_ff <= '0;
    end
    else if (push)
    begin
      mem_ff[wp_ff] <= wr.data;
      wp_ff <= (wp_ff == AW'(DEPTH - 1)) ? '0 : wp_ff + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      rp_ff <= '0;
    else if (pop)
      rp_ff <= (rp_ff == AW'(DEPTH - 1)) ? '0 : rp_ff + 1'b1;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      cnt_ff <= '0;
    else if (push && !pop)
      cnt_ff <= cnt_ff + 1'b1;
    else if (pop && !push)
      cnt_ff <= cnt_ff - 1'b1;
  end
endmodule : msl_fifo2
`default_nettype wire

// *** msl_link.sv ***
// Station side of the addressed half-duplex serial link.
`timescale 1ns/1ps
`default_nettype none
module msl_link #(
  parameter int unsigned BIT_CYC_19200 = msl_pkg::CYC_19200,
  parameter int unsigned BIT_CYC_9600  = msl_pkg::CYC_9600,
  parameter int unsigned BIT_CYC_4800  = msl_pkg::CYC_4800
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        rxd,
  output var  logic        txd,
  output var  logic        txd_oe,
  input  wire logic [15:0] station_address_setting,
  input  wire logic [15:0] link_bit_rate_setting,
  input  wire logic [15:0] stop_and_length_setting,
  input  wire logic [15:0] parity_setting,
  input  wire logic [15:0] retry_limit_setting,
  input  wire logic        terminator_enable,
  input  wire logic        wait_time_enable,
  output var  logic [15:0] rx_value,
  output var  logic        rx_value_valid,
  input  wire logic        rx_value_ready,
  output var  logic        link_active,
  output var  logic        link_error_trip,
  output var  logic        minor_fault_output
);
  import msl_pkg::*;

  logic [15:0]   act_addr_ff;
  logic [15:0]   act_limit_ff;
  logic [CW-1:0] bit_cyc_ff;
  logic          cfg_taken_ff, cfg_ok_ff, seven_ff, two_stop_ff;
  logic          par_en_ff, par_odd_ff, term_ff, wait_ff, inf_ff;
  logic          rxd_m_ff, rxd_s_ff;
  msl_rx_e       rx_st_ff;
  logic [CW-1:0] rx_cnt_ff;
  logic [2:0]    rx_bit_ff;
  logic [7:0]    rx_sh_ff;
  logic          rx_par_ff, rx_perr_ff, rx_done_ff, rx_err_ff;
  logic [GW-1:0] gap_ff;
  logic [1:0]    fr_idx_ff;
  logic [7:0]    fr_addr_ff, fr_hi_ff, fr_lo_ff, fr_sum_ff, fr_chk_ff;
  logic          fr_bad_ff, fr_done_ff;
  logic [4:0]    err_cnt_ff;
  logic          trip_ff;
  msl_tx_e       tx_st_ff;
  logic [CW-1:0] tx_cnt_ff;
  logic [3:0]    tx_bit_ff;
  logic [7:0]    tx_sh_ff;
  logic [1:0]    tx_idx_ff;
  logic          tx_par_ff, txd_ff, txd_oe_ff;
  logic          run, rx_tick, tx_tick, match, good, rsp_req, push, err_evt;
  logic [2:0]    last_bit;
  logic [15:0]   raw_word;

  msl_buf_if #(.W(16)) in_if ();
  msl_buf_if #(.W(16)) out_if ();

  msl_fifo2 #(.W(16), .DEPTH(2)) u_buf (
    .mclk    (mclk),
    .reset_n (reset_n),
    .wr      (in_if.snk),
    .rd      (out_if.src)
  );

  // Settings are sampled once after reset release, so later changes on the
  // setting inputs stay dormant until the next reset.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_taken_ff <= 1'b0;
      cfg_ok_ff    <= 1'b0;
      act_addr_ff  <= ADDR_RESET;
      act_limit_ff <= '0;
      bit_cyc_ff   <= CW'(BIT_CYC_19200);
      seven_ff     <= 1'b0;
      two_stop_ff  <= 1'b0;
      par_en_ff    <= 1'b0;
      par_odd_ff   <= 1'b0;
      term_ff      <= 1'b0;
      wait_ff      <= 1'b0;
      inf_ff       <= 1'b0;
    end
    else if (!cfg_taken_ff) // RL9
    begin
      cfg_taken_ff <= 1'b1;
      act_addr_ff  <= station_address_setting;
      act_limit_ff <= retry_limit_setting;
      bit_cyc_ff   <= (link_bit_rate_setting == RATE_4800) ? // RL3
                      CW'(BIT_CYC_4800) :
                      (link_bit_rate_setting == RATE_9600) ?
                      CW'(BIT_CYC_9600) : CW'(BIT_CYC_19200);
      seven_ff     <= (stop_and_length_setting == SL_7_1) || // RL11
                      (stop_and_length_setting == SL_7_2);
      two_stop_ff  <= (stop_and_length_setting == SL_8_2) ||
                      (stop_and_length_setting == SL_7_2);
      par_en_ff    <= (parity_setting != PAR_NONE);
      par_odd_ff   <= (parity_setting == PAR_ODD);
      term_ff      <= terminator_enable;
      wait_ff      <= wait_time_enable;
      inf_ff       <= (retry_limit_setting == RETRY_INF) ||
                      (retry_limit_setting == RETRY_INF_RAW);
      cfg_ok_ff    <= (station_address_setting <= ADDR_MAX) && // RL10
                      ((link_bit_rate_setting == RATE_4800) ||
                       (link_bit_rate_setting == RATE_9600) ||
                       (link_bit_rate_setting == RATE_19200)) &&
                      ((stop_and_length_setting == SL_8_1) ||
                       (stop_and_length_setting == SL_8_2) ||
                       (stop_and_length_setting == SL_7_1) ||
                       (stop_and_length_setting == SL_7_2)) &&
                      (parity_setting <= PAR_EVEN) &&
                      ((retry_limit_setting <= RETRY_MAX) ||
                       (retry_limit_setting == RETRY_INF) ||
                       (retry_limit_setting == RETRY_INF_RAW));
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rxd_m_ff <= 1'b1;
      rxd_s_ff <= 1'b1;
    end
    else
    begin
      rxd_m_ff <= rxd;
      rxd_s_ff <= rxd_m_ff;
    end
  end

  assign run      = cfg_ok_ff && !trip_ff; // RL10 RL12
  assign last_bit = seven_ff ? LAST_BIT7 : LAST_BIT8; // RL4
  assign rx_tick  = (rx_cnt_ff == '0);
  assign tx_tick  = (tx_cnt_ff == '0);

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_st_ff <= RX_IDLE;
      rx_cnt_ff <= '0;
      rx_bit_ff <= '0;
      rx_sh_ff <= '0;
      rx_par_ff <= 1'b0;
      rx_perr_ff <= 1'b0;
      rx_done_ff <= 1'b0;
      rx_err_ff <= 1'b0;
    end
    else
    begin
      rx_done_ff <= 1'b0;
      rx_cnt_ff <= rx_tick ? bit_cyc_ff - 1'b1 : rx_cnt_ff - 1'b1;
      case (rx_st_ff)
        RX_IDLE:
          if (run && !rxd_s_ff && tx_st_ff == TX_IDLE)
          begin
            rx_st_ff <= RX_START;
            rx_cnt_ff <= bit_cyc_ff >> 1;
          end
        RX_START:
          if (rx_tick)
          begin
            rx_st_ff <= rxd_s_ff ? RX_IDLE : RX_DATA;
            rx_bit_ff <= '0;
            rx_sh_ff <= '0;
            rx_par_ff <= 1'b0;
            rx_perr_ff <= 1'b0;
          end
        RX_DATA:
          if (rx_tick)
          begin
            rx_sh_ff[rx_bit_ff] <= rxd_s_ff;
            rx_par_ff <= rx_par_ff ^ rxd_s_ff;
            rx_bit_ff <= rx_bit_ff + 1'b1;
            if (rx_bit_ff == last_bit)
              rx_st_ff <= par_en_ff ? RX_PAR : RX_STOP;
          end
        RX_PAR:
          if (rx_tick)
          begin
            rx_perr_ff <= ((rx_par_ff ^ rxd_s_ff) != par_odd_ff); // RL6
            rx_st_ff <= RX_STOP;
          end
        RX_STOP:
          if (rx_tick)
          begin
            // The second stop bit, if any, is simply idle line time.
            rx_done_ff <= 1'b1;
            rx_err_ff <= rx_perr_ff || !rxd_s_ff;
            rx_st_ff <= RX_IDLE;
          end
        default:
          rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  // A long idle line realigns framing, so one lost character cannot shift
  // every later frame by one position.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      gap_ff <= '0;
    else if (rx_st_ff != RX_IDLE || fr_idx_ff == '0)
      gap_ff <= '0;
    else if (gap_ff != (GW'(bit_cyc_ff) << GAP_SHIFT))
      gap_ff <= gap_ff + 1'b1;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fr_idx_ff <= '0;
      fr_addr_ff <= '0;
      fr_hi_ff <= '0;
      fr_lo_ff <= '0;
      fr_sum_ff <= '0;
      fr_chk_ff <= '0;
      fr_bad_ff <= 1'b0;
      fr_done_ff <= 1'b0;
    end
    else
    begin
      fr_done_ff <= 1'b0;
      if (gap_ff == (GW'(bit_cyc_ff) << GAP_SHIFT))
        fr_idx_ff <= '0;
      else if (rx_done_ff)
      begin
        fr_idx_ff <= fr_idx_ff + 1'b1;
        fr_bad_ff <= (fr_idx_ff == '0) ? rx_err_ff : fr_bad_ff | rx_err_ff;
        fr_sum_ff <= (fr_idx_ff == '0) ? rx_sh_ff : fr_sum_ff + rx_sh_ff;
        case (fr_idx_ff)
          2'h0: fr_addr_ff <= rx_sh_ff;
          2'h1: fr_hi_ff <= rx_sh_ff;
          2'h2: fr_lo_ff <= rx_sh_ff;
          default:
          begin
            fr_chk_ff <= rx_sh_ff;
            fr_sum_ff <= fr_sum_ff;
            fr_done_ff <= 1'b1;
          end
        endcase
      end
    end
  end

  assign match    = ({8'h00, fr_addr_ff} == act_addr_ff); // RL1
  assign good     = !fr_bad_ff && (fr_sum_ff == fr_chk_ff); // RL15
  assign rsp_req  = fr_done_ff && match && run;
  assign raw_word = {fr_hi_ff, fr_lo_ff};
  assign push     = rsp_req && good && in_if.ready;
  assign err_evt  = rsp_req && !good; // RL15
  assign in_if.valid  = rsp_req && good;
  assign in_if.data   = msl_xlate(raw_word); // RL8
  assign out_if.ready = rx_value_ready;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      err_cnt_ff <= '0;
    else if (err_evt && err_cnt_ff != ERR_SAT)
      err_cnt_ff <= err_cnt_ff + 1'b1; // RL12
    else if (push)
      err_cnt_ff <= '0;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      trip_ff <= 1'b0;
    else if (!inf_ff && {11'h000, err_cnt_ff} > act_limit_ff) // RL12 RL13
      trip_ff <= 1'b1;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_st_ff <= TX_IDLE;
      tx_cnt_ff <= '0;
      tx_bit_ff <= '0;
      tx_sh_ff <= '0;
      tx_idx_ff <= '0;
      tx_par_ff <= 1'b0;
    end
    else
    begin
      tx_cnt_ff <= tx_tick ? bit_cyc_ff - 1'b1 : tx_cnt_ff - 1'b1;
      case (tx_st_ff)
        TX_IDLE:
          if (rsp_req)
          begin
            tx_sh_ff <= push ? CHAR_ACK : CHAR_NAK;
            tx_idx_ff <= '0;
            tx_bit_ff <= '0;
            tx_par_ff <= 1'b0;
            tx_cnt_ff <= bit_cyc_ff - 1'b1;
            tx_st_ff <= wait_ff ? TX_WAIT : TX_START; // RL7
          end
        TX_WAIT:
          if (tx_tick)
          begin
            tx_bit_ff <= tx_bit_ff + 1'b1;
            if (tx_bit_ff == WAIT_LAST)
              tx_st_ff <= TX_START;
          end
        TX_START:
          if (tx_tick)
          begin
            tx_bit_ff <= '0;
            tx_st_ff <= TX_DATA;
          end
        TX_DATA:
          if (tx_tick)
          begin
            tx_sh_ff <= tx_sh_ff >> 1;
            tx_par_ff <= tx_par_ff ^ tx_sh_ff[0];
            tx_bit_ff <= tx_bit_ff + 1'b1;
            if (tx_bit_ff[2:0] == last_bit) // RL4
            begin
              tx_bit_ff <= '0;
              tx_st_ff <= par_en_ff ? TX_PAR : TX_STOP;
            end
          end
        TX_PAR:
          if (tx_tick)
            tx_st_ff <= TX_STOP;
        TX_STOP:
          if (tx_tick)
          begin
            tx_par_ff <= 1'b0;
            if (two_stop_ff && tx_bit_ff == '0) // RL5
              tx_bit_ff <= 4'h1;
            else if (term_ff && tx_idx_ff != 2'h2)
            begin
              tx_idx_ff <= tx_idx_ff + 1'b1;
              tx_sh_ff <= (tx_idx_ff == '0) ? CHAR_CR : CHAR_LF;
              tx_st_ff <= TX_START;
            end
            else
              tx_st_ff <= TX_IDLE; // RL14
          end
        default:
          tx_st_ff <= TX_IDLE;
      endcase
    end
  end

  // Driver enable covers start to last stop bit only; the wait interval
  // leaves the line to the host so a late host frame cannot collide.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txd_ff <= 1'b1;
      txd_oe_ff <= 1'b0;
    end
    else
    begin
      txd_oe_ff <= (tx_st_ff == TX_START) || (tx_st_ff == TX_DATA) || // RL14
                   (tx_st_ff == TX_PAR) || (tx_st_ff == TX_STOP);
      case (tx_st_ff)
        TX_START: txd_ff <= 1'b0;
        TX_DATA:  txd_ff <= tx_sh_ff[0];
        TX_PAR:   txd_ff <= tx_par_ff ^ par_odd_ff; // RL6
        default:  txd_ff <= 1'b1;
      endcase
    end
  end

  assign txd                = txd_ff;
  assign txd_oe             = txd_oe_ff;
  assign rx_value           = out_if.data;
  assign rx_value_valid     = out_if.valid;
  assign link_active        = run;
  assign link_error_trip    = trip_ff;
  assign minor_fault_output = inf_ff && (err_cnt_ff != '0); // RL13

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  AST_ADDR_ONLY: assert property (rsp_req |-> fr_addr_ff == act_addr_ff[7:0]) // RL1
    else $error("Reply started for a foreign station address.");
  AST_RATE_SET: assert property (cfg_taken_ff |-> bit_cyc_ff == CW'(BIT_CYC_4800) || bit_cyc_ff == CW'(BIT_CYC_9600) || bit_cyc_ff == CW'(BIT_CYC_19200)) // RL3
    else $error("Bit period is not one of the three rates.");
  AST_CHAR_LEN: assert property (tx_st_ff == TX_DATA && tx_tick && tx_bit_ff[2:0] == last_bit |=> tx_st_ff != TX_DATA) // RL4
    else $error("Transmit data phase ran past the character length.");
  AST_TWO_STOP: assert property (tx_st_ff == TX_STOP && tx_tick && two_stop_ff && tx_bit_ff == 4'h0 |=> tx_st_ff == TX_STOP) // RL5
    else $error("Second stop bit was skipped.");
  AST_PARITY_NAK: assert property (rsp_req && fr_bad_ff |-> !push ##1 tx_sh_ff == CHAR_NAK) // RL6
    else $error("Character error did not lead to a refusal.");
  AST_WAIT_GAP: assert property (tx_st_ff == TX_IDLE && rsp_req && wait_ff |=> !txd_oe_ff [*2] ##0 tx_st_ff == TX_WAIT) // RL7
    else $error("Reply did not wait before driving.");
  AST_XLATE: assert property (push && raw_word == RAW_8888 |-> in_if.data == VAL_8888) // RL8
    else $error("Special value 8888 not translated.");
  AST_CFG_HOLD: assert property (cfg_taken_ff |=> $stable(act_addr_ff) && $stable(bit_cyc_ff) && $stable(cfg_ok_ff)) // RL9
    else $error("Active settings changed without reset.");
  AST_BAD_CFG_MUTE: assert property (cfg_taken_ff && !cfg_ok_ff |-> !txd_oe_ff && !in_if.valid && rx_st_ff == RX_IDLE) // RL10
    else $error("Link exchanged data with invalid settings.");
  AST_TRIP: assert property (!inf_ff && err_evt && {11'h000, err_cnt_ff} == act_limit_ff |-> ##2 trip_ff) // RL12
    else $error("Error count above limit did not trip.");
  AST_NO_TRIP_INF: assert property (inf_ff && err_evt |-> ##1 minor_fault_output && !trip_ff) // RL13
    else $error("Unlimited retry mode tripped or gave no minor fault.");
  AST_RELEASE: assert property ($fell(txd_oe_ff) |-> txd_ff && tx_st_ff == TX_IDLE) // RL14
    else $error("Line released mid character.");
  AST_SUM_FAIL: assert property (rsp_req && fr_sum_ff != fr_chk_ff |=> err_cnt_ff != 5'h00) // RL15
    else $error("Sum mismatch was not counted.");

  COV_GOOD_WORD: cover property (push ##1 rx_value_valid);
  COV_TRIP: cover property ($rose(trip_ff));
  COV_TERM_REPLY: cover property (tx_st_ff == TX_STOP && tx_idx_ff == 2'h2);
  COV_FULL_NAK: cover property (rsp_req && good && !in_if.ready);
endmodule : msl_link
`default_nettype wire

// *** msl_host.sv ***
// Host model that polls one station over the shared serial line.
`timescale 1ns/1ps
`default_nettype none
module msl_host #(
  parameter int BIT = 16
) (
  input  wire logic mclk,
  output var  logic rxd,
  input  wire logic txd,
  input  wire logic txd_oe
);
  int bit_cyc = BIT;
  initial rxd = 1'b1;
  // Eight data bits, lowest first, no parity, one stop bit.
  task automatic send_byte(input logic [7:0] b);
    int i;
    rxd <= 1'b0;
    repeat (bit_cyc) @(posedge mclk);
    for (i = 0; i < 8; i++)
    begin
      rxd <= b[i];
      repeat (bit_cyc) @(posedge mclk);
    end
    rxd <= 1'b1;
    repeat (bit_cyc) @(posedge mclk);
  endtask : send_byte
  // A nonzero skew corrupts the sum on purpose.
  task automatic send_frame(input logic [7:0] a, hi, lo, skew);
    send_byte(a);
    send_byte(hi);
    send_byte(lo);
    send_byte(a + hi + lo + skew);
  endtask : send_frame
  task automatic get_byte(output logic [7:0] b, output logic ok);
    int n;
    int i;
    n = 0;
    b = 8'h00;
    while (!(txd_oe === 1'b1 && txd === 1'b0) && n < 60 * bit_cyc)
    begin
      @(posedge mclk);
      n++;
    end
    ok = (n < 60 * bit_cyc);
    if (ok)
    begin
      repeat (bit_cyc / 2) @(posedge mclk);
      for (i = 0; i < 8; i++)
      begin
        repeat (bit_cyc) @(posedge mclk);
        b[i] = txd;
      end
      // Stay quiet until the station has released the line.
      repeat (2 * bit_cyc) @(posedge mclk);
    end
  endtask : get_byte
endmodule : msl_host
`default_nettype wire

// *** msl_link_tb.sv ***
// Self-checking bench for the station link logic.
`timescale 1ns/1ps
`default_nettype none
module msl_link_tb;
  import msl_pkg::*;
  logic        mclk, reset_n, rxd, txd, txd_oe, rx_value_valid;
  logic        rx_value_ready, link_active, link_error_trip, minor;
  logic        wait_set;
  logic [15:0] addr_set, rate_set, limit_set, rx_value;
  int          bad_count, n_compared, cycles;
  msl_host #(.BIT(16)) host (.mclk(mclk), .rxd(rxd), .txd(txd),
    .txd_oe(txd_oe));
  msl_link #(.BIT_CYC_19200(16), .BIT_CYC_9600(24), .BIT_CYC_4800(32)) dut (
    .mclk(mclk), .reset_n(reset_n), .rxd(rxd), .txd(txd), .txd_oe(txd_oe),
    .station_address_setting(addr_set), .link_bit_rate_setting(rate_set),
    .stop_and_length_setting(SL_8_1), .parity_setting(PAR_NONE),
    .retry_limit_setting(limit_set), .terminator_enable(1'b0),
    .wait_time_enable(wait_set), .rx_value(rx_value),
    .rx_value_valid(rx_value_valid), .rx_value_ready(rx_value_ready),
    .link_active(link_active), .link_error_trip(link_error_trip),
    .minor_fault_output(minor));
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic summarize;
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  // Runs well past the longest expected sequence before giving up.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      bad_count++;
      summarize();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic start(input logic [15:0] a, r, l, input int bc);
    reset_n <= 1'b0;
    addr_set <= a;
    rate_set <= r;
    limit_set <= l;
    host.bit_cyc = bc;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : start
  task automatic exch(input logic [7:0] a, hi, lo, skew, input logic ok_e,
    input logic [7:0] b_e);
    logic [7:0] b;
    logic       ok;
    fork
      host.send_frame(a, hi, lo, skew);
      host.get_byte(b, ok);
    join
    check({15'h0, ok}, {15'h0, ok_e});
    if (ok_e)
    begin
      check({8'h0, b}, {8'h0, b_e});
      check({15'h0, txd_oe}, 16'h0000);
    end
  endtask : exch
  task automatic pop(input logic [15:0] exp);
    check({15'h0, rx_value_valid}, 16'h0001);
    check(rx_value, exp);
    rx_value_ready <= 1'b1;
    @(posedge mclk);
    rx_value_ready <= 1'b0;
    @(posedge mclk);
  endtask : pop
  task automatic t_good;
    start(16'h001F, RATE_19200, RETRY_MAX, 16);
    check({15'h0, link_active}, 16'h0001);
    exch(8'h1F, 8'h12, 8'h34, 8'h00, 1'b1, CHAR_ACK);
    pop(16'h1234);
    exch(8'h1F, 8'hFF, 8'hF0, 8'h00, 1'b1, CHAR_ACK);
    pop(VAL_8888);
    exch(8'h1F, 8'hFF, 8'hFF, 8'h00, 1'b1, CHAR_ACK);
    pop(VAL_9999);
  endtask : t_good
  task automatic t_full;
    start(16'h0005, RATE_19200, 16'h0000, 16);
    exch(8'h05, 8'h00, 8'h01, 8'h00, 1'b1, CHAR_ACK);
    exch(8'h05, 8'h00, 8'h02, 8'h00, 1'b1, CHAR_ACK);
    exch(8'h05, 8'h00, 8'h03, 8'h00, 1'b1, CHAR_NAK);
    check({15'h0, link_error_trip}, 16'h0000);
    pop(16'h0001);
    pop(16'h0002);
    check({15'h0, rx_value_valid}, 16'h0000);
  endtask : t_full
  task automatic t_addr;
    start(16'h0005, RATE_19200, RETRY_MAX, 16);
    addr_set <= 16'h0006;
    exch(8'h06, 8'h00, 8'h07, 8'h00, 1'b0, 8'h00);
    exch(8'h05, 8'h00, 8'h08, 8'h00, 1'b1, CHAR_ACK);
    pop(16'h0008);
  endtask : t_addr
  task automatic t_trip;
    start(16'h0005, RATE_4800, 16'h0000, 32);
    exch(8'h05, 8'h01, 8'h02, 8'h01, 1'b1, CHAR_NAK);
    repeat (4) @(posedge mclk);
    check({15'h0, link_error_trip}, 16'h0001);
    check({15'h0, link_active}, 16'h0000);
    exch(8'h05, 8'h01, 8'h02, 8'h00, 1'b0, 8'h00);
  endtask : t_trip
  task automatic t_minor;
    start(16'h0005, RATE_9600, RETRY_INF, 24);
    exch(8'h05, 8'h01, 8'h02, 8'h03, 1'b1, CHAR_NAK);
    check({15'h0, minor}, 16'h0001);
    check({15'h0, link_error_trip}, 16'h0000);
    exch(8'h05, 8'h01, 8'h02, 8'h00, 1'b1, CHAR_ACK);
    check({15'h0, minor}, 16'h0000);
    pop(16'h0102);
  endtask : t_minor
  // The reply must leave the line quiet for the waiting interval.
  task automatic t_wait;
    logic [7:0] b;
    logic       ok;
    int         t0;
    int         t1;
    wait_set <= 1'b1;
    start(16'h0005, RATE_19200, RETRY_MAX, 16);
    fork
      begin
        host.send_frame(8'h05, 8'h00, 8'h09, 8'h00);
        t0 = cycles;
      end
      begin
        wait (txd_oe === 1'b1);
        t1 = cycles;
      end
      host.get_byte(b, ok);
    join
    check({15'h0, ok && (t1 - t0 > 9 * 16)}, 16'h0001);
    check({8'h0, b}, {8'h0, CHAR_ACK});
    pop(16'h0009);
    wait_set <= 1'b0;
  endtask : t_wait
  task automatic t_invalid;
    start(16'h0005, 16'h0055, RETRY_MAX, 16);
    check({15'h0, link_active}, 16'h0000);
    exch(8'h05, 8'h01, 8'h02, 8'h00, 1'b0, 8'h00);
  endtask : t_invalid
  initial
  begin
    reset_n = 1'b0;
    rx_value_ready = 1'b0;
    wait_set = 1'b0;
    addr_set = 16'h0000;
    rate_set = RATE_RESET;
    limit_set = RETRY_MAX;
    bad_count = 0;
    n_compared = 0;
    cycles = 0;
    @(posedge mclk);
    t_good();
    t_full();
    t_addr();
    t_trip();
    t_minor();
    t_wait();
    t_invalid();
    summarize();
  end
endmodule : msl_link_tb
`default_nettype wire
